// *** logic/synth_modem_config_regs.v ***
// Contract
// - Five-bit IF word, reset fifteen, RX only
// - In RX, IF subtracted from base frequency
// - Signed offset added to base frequency
// - High carrier byte bits 7:6 read zero
// - Carrier word assembled from three bytes
// - Bandwidth exponent and mantissa set decimation
// - Bandwidth divisor is 8*(4+M)*2^E; DECIM_DIVISOR gives 8*(4+M) only, E goes out on DECIM_SHIFT
// - Rate exponent nibble, reset twelve
// - Rate mantissa low byte, read/write
// - Effective mantissa is 256 plus byte
// - Rate is mantissa shifted by exponent
`include "synth_cfg_defines.vh"

module synth_modem_config_regs (
    input  wire        REF_CLK,
    input  wire        RST,
    input  wire        WR_EN,
    input  wire        RD_EN,
    input  wire [5:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        RX_ACTIVE,
    output reg  [7:0]  RDATA,
    output reg  [23:0] SYNTH_WORD,
    output reg  [4:0]  MIXER_IF_WORD,
    output reg  [7:0]  DECIM_DIVISOR,
    output reg  [1:0]  DECIM_SHIFT,
    output reg  [8:0]  RATE_MANTISSA,
    output reg  [3:0]  RATE_EXPONENT,
    output reg  [23:0] RATE_STEP
);

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Unmapped addresses match no strobe, so their writes are dropped
    wire we_if   = WR_EN && (ADDR == `ADDR_IF_CARRIER_WORD_CTRL);
    wire we_off  = WR_EN && (ADDR == `ADDR_CARRIER_WORD_OFFSET_CTRL);
    wire we_hi   = WR_EN && (ADDR == `ADDR_CARRIER_HIGH);
    wire we_mid  = WR_EN && (ADDR == `ADDR_CARRIER_MID);
    wire we_lo   = WR_EN && (ADDR == `ADDR_CARRIER_LOW);
    wire we_bw   = WR_EN && (ADDR == `ADDR_BW_RATE_EXP);
    wire we_mant = WR_EN && (ADDR == `ADDR_RATE_MANT);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg  [4:0] if_word_r;
    reg        tune_bit_r;
    wire [7:0] synth_offset;
    wire [5:0] carrier_high;
    wire [7:0] carrier_mid;
    wire [7:0] carrier_low;
    reg  [1:0] bandwidth_exponent_r;
    reg  [1:0] bandwidth_mantissa_r;
    reg  [3:0] rate_exponent_r;
    wire [7:0] rate_mantissa;

    // Tuning bit drives nothing here; kept so software reads it back
    // IF word and tuning bit
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            if_word_r  <= `RST_IF_WORD;
            tune_bit_r <= `RST_TUNE_BIT;
        end else if (we_if) begin
            if_word_r  <= WDATA[4:0];
            tune_bit_r <= WDATA[5];
        end
    end

    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            bandwidth_exponent_r <= `RST_BW_EXP;
            bandwidth_mantissa_r <= `RST_BW_MANT;
            rate_exponent_r      <= `RST_RATE_EXP;
        end else if (we_bw) begin
            bandwidth_exponent_r <= WDATA[7:6];
            bandwidth_mantissa_r <= WDATA[5:4];
            rate_exponent_r      <= WDATA[3:0];
        end
    end

    // ------------------------------------------------------------
    // Byte-wide registers
    // ------------------------------------------------------------
    // offset byte storage
    cfg_byte_reg #(.WIDTH(8), .RESET(`RST_SYNTH_OFFSET)) u_off (
        .REF_CLK (REF_CLK),
        .RST     (RST),
        .we      (we_off),
        .din     (WDATA),
        .q_r     (synth_offset)
    );

    // Bits 7:6 have no flops, so no write can ever set them
    // only bits 5:0 of the high byte stored
    cfg_byte_reg #(.WIDTH(6), .RESET({`ZERO2, `RST_CARRIER_HIGH})) u_hi (
        .REF_CLK (REF_CLK),
        .RST     (RST),
        .we      (we_hi),
        .din     (WDATA[5:0]),
        .q_r     (carrier_high)
    );

    cfg_byte_reg #(.WIDTH(8), .RESET(`RST_CARRIER_MID)) u_mid (
        .REF_CLK (REF_CLK),
        .RST     (RST),
        .we      (we_mid),
        .din     (WDATA),
        .q_r     (carrier_mid)
    );

    cfg_byte_reg #(.WIDTH(8), .RESET(`RST_CARRIER_LOW)) u_lo (
        .REF_CLK (REF_CLK),
        .RST     (RST),
        .we      (we_lo),
        .din     (WDATA),
        .q_r     (carrier_low)
    );

    cfg_byte_reg #(.WIDTH(8), .RESET(`RST_RATE_MANT)) u_mant (
        .REF_CLK (REF_CLK),
        .RST     (RST),
        .we      (we_mant),
        .din     (WDATA),
        .q_r     (rate_mantissa)
    );

    // ------------------------------------------------------------
    // Derived synthesizer and modem values
    // ------------------------------------------------------------
    // assemble carrier word
    wire [23:0] carrier_word = {`ZERO2, carrier_high, carrier_mid,
                                carrier_low};

    // offset step is 2^14 vs carrier 2^16, so scale by four
    wire [23:0] offset_scaled = {{14{synth_offset[7]}}, synth_offset,
                                 `ZERO2};

    // IF step 2^10 is 64 carrier steps
    wire [23:0] if_scaled = {13'h0000, if_word_r, 6'h00};

    // Word wraps modulo 2^24 as the synthesizer sees it; the carry
    // is dropped on purpose rather than saturated
    wire [24:0] base_sum   = {1'b0, carrier_word} + {1'b0, offset_scaled};
    wire [23:0] synth_base = base_sum[23:0];
    wire [24:0] rx_diff    = {1'b0, synth_base} - {1'b0, if_scaled};
    // IF taken off only while receiving
    wire [23:0] synth_nxt  = RX_ACTIVE ? rx_diff[23:0] : synth_base;

    // ------------------------------------------------------------
    // Modem rate and bandwidth
    // ------------------------------------------------------------
    // hidden leading one
    wire [8:0] mant_eff = {`HIDDEN_ONE, rate_mantissa};

    // step per crystal cycle in 2^-28 units
    wire [23:0] rate_nxt = {15'h0000, mant_eff} << rate_exponent_r;

    // divisor 8*(4+M); E is not applied here and leaves on DECIM_SHIFT
    wire [2:0] bw_sum    = `BW_MANT_BASE + {1'b0, bandwidth_mantissa_r};
    wire [7:0] decim_nxt = {2'h0, bw_sum, 3'h0};

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Reads have no side effects, so a stray read is harmless
    reg [7:0] rdata_nxt;
    always @* begin
        case (ADDR)
            `ADDR_IF_CARRIER_WORD_CTRL:     rdata_nxt = {`ZERO2, tune_bit_r,
                                                 if_word_r};
            `ADDR_CARRIER_WORD_OFFSET_CTRL: rdata_nxt = synth_offset;
            `ADDR_CARRIER_HIGH:     rdata_nxt = {`ZERO2, carrier_high};
            `ADDR_CARRIER_MID:      rdata_nxt = carrier_mid;
            `ADDR_CARRIER_LOW:      rdata_nxt = carrier_low;
            `ADDR_BW_RATE_EXP:      rdata_nxt = {bandwidth_exponent_r,
                                                 bandwidth_mantissa_r,
                                                 rate_exponent_r};
            `ADDR_RATE_MANT:        rdata_nxt = rate_mantissa;
            default:                rdata_nxt = `ZERO8;
        endcase
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Outputs lag storage by one cycle so every port is a flop
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RDATA         <= `ZERO8;
            SYNTH_WORD    <= 24'h000000;
            MIXER_IF_WORD <= 5'h00;
            DECIM_DIVISOR <= `ZERO8;
            DECIM_SHIFT   <= `ZERO2;
            RATE_MANTISSA <= 9'h000;
            RATE_EXPONENT <= 4'h0;
            RATE_STEP     <= 24'h000000;
        end else begin
            // Read data holds between reads so a slow host can sample late
            if (RD_EN) begin
                RDATA <= rdata_nxt;
            end
            SYNTH_WORD    <= synth_nxt;
            MIXER_IF_WORD <= RX_ACTIVE ? if_word_r : 5'h00;
            DECIM_DIVISOR <= decim_nxt;
            DECIM_SHIFT   <= bandwidth_exponent_r;
            RATE_MANTISSA <= mant_eff;
            RATE_EXPONENT <= rate_exponent_r;
            RATE_STEP     <= rate_nxt;
        end
    end

endmodule // synth_modem_config_regs

// *** logic/synth_cfg_defines.vh ***
`ifndef SYNTH_CFG_DEFINES_VH
`define SYNTH_CFG_DEFINES_VH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define ADDR_IF_CARRIER_WORD_CTRL      6'h0B
`define ADDR_CARRIER_WORD_OFFSET_CTRL  6'h0C
`define ADDR_CARRIER_HIGH      6'h0D
`define ADDR_CARRIER_MID       6'h0E
`define ADDR_CARRIER_LOW       6'h0F
`define ADDR_BW_RATE_EXP       6'h10
`define ADDR_RATE_MANT         6'h11

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_IF_WORD            5'h0F
`define RST_TUNE_BIT           1'h0
`define RST_SYNTH_OFFSET       8'h00
`define RST_CARRIER_HIGH       6'h1E
`define RST_CARRIER_MID        8'hC4
`define RST_CARRIER_LOW        8'hEC
`define RST_BW_EXP             2'h2
`define RST_BW_MANT            2'h0
`define RST_RATE_EXP           4'hC
`define RST_RATE_MANT          8'h22

// ------------------------------------------------------------
// Field constants
// ------------------------------------------------------------
`define HIDDEN_ONE             1'h1
`define BW_MANT_BASE           3'h4
`define ZERO2                  2'h0
`define ZERO8                  8'h00

`endif

// *** logic/cfg_byte_reg.v ***
// ------------------------------------------------------------
// Generic writable field, WIDTH bits up to a byte wide
// ------------------------------------------------------------
module cfg_byte_reg #(
    parameter       WIDTH = 8,
    parameter [7:0] RESET = 8'h00
) (
    input  wire             REF_CLK,
    input  wire             RST,
    input  wire             we,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] q_r
);
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            q_r <= RESET[WIDTH-1:0];
        end else if (we) begin
            q_r <= din;
        end
    end
endmodule // cfg_byte_reg

// *** verification/cfg_regs_checker_properties.sv ***
// ----------------------------------------
// Port checks of the register bank
// ----------------------------------------
module cfg_regs_checker (
    input logic        REF_CLK,
    input logic        RST,
    input logic        WR_EN,
    input logic        RD_EN,
    input logic [5:0]  ADDR,
    input logic [7:0]  WDATA,
    input logic        RX_ACTIVE,
    input logic [7:0]  RDATA,
    input logic [23:0] SYNTH_WORD,
    input logic [4:0]  MIXER_IF_WORD,
    input logic [7:0]  DECIM_DIVISOR,
    input logic [1:0]  DECIM_SHIFT,
    input logic [8:0]  RATE_MANTISSA,
    input logic [3:0]  RATE_EXPONENT,
    input logic [23:0] RATE_STEP
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Derived outputs are zero for one edge after reset; the check waits out two
    property p_div; !$past(RST) && !$past(RST, 2) |->
        DECIM_DIVISOR[2:0] == 3'h0
        && DECIM_DIVISOR >= 8'h20 && DECIM_DIVISOR <= 8'h38; endproperty
    a_div: assert property (p_div) else $error("bad divisor");
    property p_mant; !$past(RST) && !$past(RST, 2) |-> RATE_MANTISSA[8];
    endproperty
    a_mant: assert property (p_mant) else $error("hidden one lost");
    property p_step; RATE_STEP == ({15'h0000, RATE_MANTISSA} << RATE_EXPONENT);
    endproperty
    a_step: assert property (p_step) else $error("rate step wrong");
    property p_mix; !RX_ACTIVE [*3] |-> MIXER_IF_WORD == 5'h00; endproperty
    a_mix: assert property (p_mix) else $error("IF word out of RX");
    property p_hi; RD_EN && ADDR == 6'h0D |=> RDATA[7:6] == 2'h0; endproperty
    a_hi: assert property (p_hi) else $error("high bits set");
    property p_unm; RD_EN && (ADDR < 6'h0B || ADDR > 6'h11) |=> RDATA == 8'h00;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped not zero");
    property p_hold; !RD_EN |=> $stable(RDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_wr; WR_EN && ADDR == 6'h0E ##1 RD_EN && ADDR == 6'h0E
        |=> RDATA == $past(WDATA, 2); endproperty
    a_wr: assert property (p_wr) else $error("readback wrong");
    c_wr: cover property (WR_EN && ADDR == 6'h0D);
    c_b2b: cover property (WR_EN ##1 RD_EN);
    c_rx: cover property (RX_ACTIVE && SYNTH_WORD != 24'h1EC4EC);
endmodule // cfg_regs_checker

bind synth_modem_config_regs cfg_regs_checker cfg_regs_checker_inst (
    .REF_CLK(REF_CLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
    .WDATA(WDATA), .RX_ACTIVE(RX_ACTIVE), .RDATA(RDATA),
    .SYNTH_WORD(SYNTH_WORD), .MIXER_IF_WORD(MIXER_IF_WORD),
    .DECIM_DIVISOR(DECIM_DIVISOR), .DECIM_SHIFT(DECIM_SHIFT),
    .RATE_MANTISSA(RATE_MANTISSA), .RATE_EXPONENT(RATE_EXPONENT),
    .RATE_STEP(RATE_STEP));

// *** verification/cfg_host_model.sv ***
// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module cfg_host_model (
    input  logic       REF_CLK,
    output logic       WR_EN,
    output logic       RD_EN,
    output logic [5:0] ADDR,
    output logic [7:0] WDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {WR_EN, RD_EN, ADDR, WDATA} = 16'h0000;
    // Each call owns one cycle, so back-to-back calls never double-drive
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        {WR_EN, RD_EN, ADDR, WDATA} <= {2'b10, a, d};
    endtask
    // Data lines toggle once released, so a stale byte never looks valid
    task rd(input logic [5:0] a);
        @(posedge REF_CLK);
        {WR_EN, RD_EN, ADDR, WDATA} <= {2'b01, a, ~WDATA};
    endtask
    task idle;
        @(posedge REF_CLK);
        {WR_EN, RD_EN, WDATA} <= {2'b00, ~WDATA};
    endtask
endmodule // cfg_host_model

// *** verification/test_synth_modem_config_regs.sv ***
module test_synth_modem_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        REF_CLK = 1'b0, RST = 1'b1, RX_ACTIVE = 1'b0, rd_pend = 1'b0;
    wire         WR_EN, RD_EN;
    wire  [5:0]  ADDR;
    wire  [7:0]  WDATA, RDATA, DECIM_DIVISOR;
    wire  [23:0] SYNTH_WORD, RATE_STEP;
    wire  [4:0]  MIXER_IF_WORD;
    wire  [1:0]  DECIM_SHIFT;
    wire  [8:0]  RATE_MANTISSA;
    wire  [3:0]  RATE_EXPONENT;
    int          n_errors = 0, check_count = 0, seed = 32'h6A54, i, k;
    logic [7:0]  m [11:17] = '{8'h0F, 8'h00, 8'h1E, 8'hC4,
                               8'hEC, 8'h8C, 8'h22};
    logic [7:0]  q [$];
    logic [7:0]  d;
    synth_modem_config_regs synth_modem_config_regs_inst (
        .REF_CLK(REF_CLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .ADDR(ADDR), .WDATA(WDATA), .RX_ACTIVE(RX_ACTIVE), .RDATA(RDATA),
        .SYNTH_WORD(SYNTH_WORD), .MIXER_IF_WORD(MIXER_IF_WORD),
        .DECIM_DIVISOR(DECIM_DIVISOR), .DECIM_SHIFT(DECIM_SHIFT),
        .RATE_MANTISSA(RATE_MANTISSA), .RATE_EXPONENT(RATE_EXPONENT),
        .RATE_STEP(RATE_STEP));
    cfg_host_model cfg_host_model_inst (.REF_CLK(REF_CLK), .WR_EN(WR_EN),
        .RD_EN(RD_EN), .ADDR(ADDR), .WDATA(WDATA));
    task ck24(input logic [23:0] g, input logic [23:0] x);
        check_count++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task ck8(input logic [7:0] g, input logic [7:0] x);
        ck24({16'h0000, g}, {16'h0000, x});
    endtask
    task w(input logic [5:0] x, input logic [7:0] v);
        cfg_host_model_inst.wr(x, v);
        if (x >= 6'h0B && x <= 6'h11)
            m[x] = v & ((x == 6'h0B || x == 6'h0D) ? 8'h3F : 8'hFF);
    endtask
    task r(input logic [5:0] x);
        q.push_back((x >= 6'h0B && x <= 6'h11) ? m[x] : 8'h00);
        cfg_host_model_inst.rd(x);
    endtask
    task read_all;
        for (k = 10; k <= 18; k++) r(k[5:0]);
    endtask
    task settle;
        logic [23:0] base;
        logic [4:0]  ifw;
        logic [7:0]  div;
        repeat (3) cfg_host_model_inst.idle();
        @(negedge REF_CLK);
        base = {2'b00, m[13][5:0], m[14], m[15]}
             + {{14{m[12][7]}}, m[12], 2'b00};
        if (RX_ACTIVE)
            base = base - {13'h0000, m[11][4:0], 6'h00};
        ifw = RX_ACTIVE ? m[11][4:0] : 5'h00;
        div = 8'h08 * (8'h04 + {6'h00, m[16][5:4]});
        ck24(SYNTH_WORD, base);
        ck24({19'h0, MIXER_IF_WORD}, {19'h0, ifw});
        ck8(DECIM_DIVISOR, div);
        ck8({6'h00, DECIM_SHIFT}, {6'h00, m[16][7:6]});
        ck8({4'h0, RATE_EXPONENT}, {4'h0, m[16][3:0]});
        ck24({15'h0, RATE_MANTISSA}, {15'h0, 1'b1, m[17]});
        ck24(RATE_STEP, {15'h0000, 1'b1, m[17]} << m[16][3:0]);
    endtask
    task complete_run;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge REF_CLK) rd_pend <= RD_EN && !RST;
    always @(negedge REF_CLK)
        if (rd_pend) ck8(RDATA, q.pop_front());
    initial forever #25 REF_CLK = ~REF_CLK;
    initial begin
        repeat (20000) @(posedge REF_CLK);
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge REF_CLK);
        RST <= 1'b0;
        settle();
        read_all();
        for (i = 0; i < 6; i++) begin
            for (k = 10; k <= 18; k++) w(k[5:0], 8'($random(seed)));
            RX_ACTIVE <= 1'($random(seed));
            settle();
            read_all();
            d = 8'($random(seed));
            w(6'h0E, d);
            r(6'h0E);
        end
        w(6'h0D, 8'hFF);
        w(6'h0B, 8'hFF);
        r(6'h0D);
        r(6'h0B);
        settle();
        // Mid-run reset must restore every register
        cfg_host_model_inst.idle();
        RST <= 1'b1;
        repeat (3) cfg_host_model_inst.idle();
        RST <= 1'b0;
        m = '{8'h0F, 8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22};
        settle();
        read_all();
        repeat (2) cfg_host_model_inst.idle();
        ck24(24'(q.size()), 24'h000000);
        complete_run();
    end
endmodule // test_synth_modem_config_regs
